// *** cpu_pkg.sv ***
// Package for the compare and PWM unit: constants, modes and state carrier
package cpu_pkg;
   // Unit control mode field values (low nibble of unit_control_reg)
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_CMP_SET = 4'h8;
   localparam logic [3:0] MODE_CMP_CLR = 4'h9;
   localparam logic [3:0] MODE_CMP_TOG = 4'h2;
   localparam logic [3:0] MODE_CMP_TRIG = 4'hB;
   localparam logic [3:0] MODE_PWM = 4'hC;
   localparam int MODE_LSB = 0;
   localparam int DUTY_LSB_POS = 4;
   // Timebase control fields
   localparam int TB_ON_POS = 7;
   localparam int TB_PRE_LSB = 4;
   localparam int TB_POST_LSB = 0;
   localparam int TB_OS_POS = 3;
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [15:0] RST_CNT = 16'h0000;
   localparam logic [6:0] PRE_MAX = 7'h7F;
   // Timebase run state, Gray coded
   typedef enum logic [1:0] {
      CPU_TB_IDLE = 2'b00,
      CPU_TB_RUN = 2'b01,
      CPU_TB_DONE = 2'b11
   } cpu_tb_state_t;
   typedef struct packed {
      cpu_tb_state_t tb_state;
      logic [7:0] tb_count;
      logic [6:0] pre_count;
      logic [3:0] post_count;
      logic [9:0] duty_latch;
      logic cmp_latch;
      logic match_flag;
      logic conv_trig;
      logic wake;
      logic pin_out;
      logic pin_oe;
      logic internal_out;
      logic counter_reset;
      logic period_event;
   } cpu_state_t;
endpackage : cpu_pkg

// *** cpu_unit.sv ***
// Compare and standard PWM unit with 8-bit timebase
// How it works
// - Control register written zero forces the compare latch low.
// - Every mode sets the match event flag on its event.
// - Match with flag set fires conversion trigger when unit is trigger source.
// - Match vanishing before counter reset edge cancels that reset.
// - Matching in sleep needs running counter; enabled match wakes device.
// - Standard PWM up to ten bits on the unit pin.
// - Period, duty, resolution set by period, timebase, compare, control registers.
// - 8-bit timebase and period register, free running or one-shot.
// - Prescaler 1:1 to 1:128, postscaler 1:1 to 1:16.
// - Driver disable one turns pin driver off, zero turns it on when the pin route is selected.
// - Unit output also feeds other on-chip peripherals.
`timescale 1ns/100ps
module cpu_unit
   import cpu_pkg::*;
(
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic ce_in,
   input wire logic instr_tick_in,
   input wire logic [7:0] unit_control_reg_in,
   input wire logic [7:0] compare_value_high_in,
   input wire logic [7:0] compare_value_low_in,
   input wire logic [15:0] compare_time_counter_in,
   input wire logic [7:0] timebase_period_reg_in,
   input wire logic [7:0] timebase_control_reg_in,
   input wire logic ext_start_in,
   input wire logic pin_driver_disable_in,
   input wire logic pin_route_select_in,
   input wire logic trig_source_sel_in,
   input wire logic match_irq_enable_in,
   input wire logic sleep_in,
   input wire logic flag_clear_in,
   output logic pin_out,
   output logic pin_oe_out,
   output logic internal_out,
   output logic match_event_flag_out,
   output logic conv_trig_out,
   output logic counter_reset_out,
   output logic period_event_out,
   output logic wake_out,
   output logic [7:0] pwm_time_counter_out
);
   cpu_state_t r;
   cpu_state_t next_r;
   logic [3:0] mode;
   logic is_pwm;
   logic is_cmp;
   logic cmp_match;
   logic [6:0] pre_limit;
   logic pre_wrap;
   logic tb_wrap;
   logic tb_on;
   logic [9:0] ext_count;
   logic cmp_level;

   assign mode = unit_control_reg_in[MODE_LSB +: 4];
   assign is_pwm = (mode == MODE_PWM);
   assign is_cmp = (mode == MODE_CMP_SET) || (mode == MODE_CMP_CLR) ||
                   (mode == MODE_CMP_TOG) || (mode == MODE_CMP_TRIG);
   // Match is sampled on the live value, so a late rewrite cancels pending reset
   assign cmp_match = (compare_time_counter_in == {compare_value_high_in, compare_value_low_in});
   // Prescale ratio is 2^field, 1:1 to 1:128
   assign pre_limit = PRE_MAX >> (3'd7 - timebase_control_reg_in[TB_PRE_LSB +: 3]);
   assign pre_wrap = (r.pre_count >= pre_limit);
   assign tb_on = timebase_control_reg_in[TB_ON_POS];
   assign tb_wrap = pre_wrap && (r.tb_count >= timebase_period_reg_in);
   // Two prescaler bits extend the count to ten bits of resolution
   assign ext_count = {r.tb_count, r.pre_count[1:0]};
   assign cmp_level = (mode == MODE_CMP_SET) ? 1'b1 :
                      (mode == MODE_CMP_CLR) ? 1'b0 :
                      (mode == MODE_CMP_TOG) ? ~r.cmp_latch : r.cmp_latch;

   // Next-state logic for timebase, compare and pin
   always_comb begin
      next_r = r;
      next_r.conv_trig = 1'b0;
      next_r.counter_reset = 1'b0;
      next_r.period_event = 1'b0;
      next_r.wake = 1'b0;
      // Timebase advances on instruction ticks only
      if (tb_on && instr_tick_in) begin
         case (r.tb_state)
            CPU_TB_IDLE: begin
               if (!timebase_control_reg_in[TB_OS_POS] || ext_start_in) begin
                  next_r.tb_state = CPU_TB_RUN;
               end
            end
            CPU_TB_RUN: begin
               next_r.pre_count = pre_wrap ? 7'h00 : r.pre_count + 7'h01;
               if (tb_wrap) begin
                  next_r.tb_count = 8'h00;
                  // New duty takes effect only at a period boundary to avoid glitches
                  next_r.duty_latch = {compare_value_low_in, unit_control_reg_in[DUTY_LSB_POS +: 2]};
                  if (r.post_count == timebase_control_reg_in[TB_POST_LSB +: 4]) begin
                     next_r.post_count = 4'h0;
                     next_r.period_event = 1'b1;
                  end else begin
                     next_r.post_count = r.post_count + 4'h1;
                  end
                  if (timebase_control_reg_in[TB_OS_POS]) begin
                     next_r.tb_state = CPU_TB_DONE;
                  end
               end else if (pre_wrap) begin
                  next_r.tb_count = r.tb_count + 8'h01;
               end
            end
            CPU_TB_DONE: begin
               if (!ext_start_in) begin
                  next_r.tb_state = CPU_TB_IDLE;
               end
            end
            default: begin
               next_r.tb_state = CPU_TB_IDLE;
            end
         endcase
      end else if (!tb_on) begin
         next_r.tb_state = CPU_TB_IDLE;
         next_r.tb_count = 8'h00;
         next_r.pre_count = 7'h00;
      end
      // Compare event: sets flag, drives latch, and may wake the device
      if (is_cmp && cmp_match && !r.match_flag) begin
         next_r.match_flag = 1'b1;
         next_r.cmp_latch = cmp_level;
         next_r.wake = match_irq_enable_in && sleep_in;
      end else if (is_pwm && tb_wrap && tb_on && instr_tick_in && r.tb_state == CPU_TB_RUN) begin
         next_r.match_flag = 1'b1;
      end else if (flag_clear_in && !(is_cmp && cmp_match)) begin
         // A match in the same cycle as the clear wins, so no event is lost
         next_r.match_flag = 1'b0;
      end
      // Single-cycle pulses; a match held for many cycles retriggers every other cycle
      if (is_cmp && r.match_flag && cmp_match && trig_source_sel_in && !r.conv_trig) begin
         next_r.conv_trig = 1'b1;
      end
      // Reset only if match still holds one edge after the trigger
      if (r.conv_trig && cmp_match && mode == MODE_CMP_TRIG) begin
         next_r.counter_reset = 1'b1;
      end
      if (unit_control_reg_in == RST_CTRL) begin
         next_r.cmp_latch = 1'b0;
      end
      if (is_pwm) begin
         next_r.internal_out = (ext_count < r.duty_latch) && r.tb_state == CPU_TB_RUN;
      end else begin
         next_r.internal_out = next_r.cmp_latch;
      end
      next_r.pin_oe = !pin_driver_disable_in && pin_route_select_in;
      next_r.pin_out = next_r.pin_oe && next_r.internal_out;
   end

   // State register, frozen while clock enable is low
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         r <= '0;
      end else if (ce_in) begin
         r <= next_r;
      end
   end

   assign pin_out = r.pin_out;
   assign pin_oe_out = r.pin_oe;
   assign internal_out = r.internal_out;
   assign match_event_flag_out = r.match_flag;
   assign conv_trig_out = r.conv_trig;
   assign counter_reset_out = r.counter_reset;
   assign period_event_out = r.period_event;
   assign wake_out = r.wake;
   assign pwm_time_counter_out = r.tb_count;

   property p_zero_ctrl;
      @(posedge clk_in) disable iff (!arst_n_in)
      (ce_in && unit_control_reg_in == RST_CTRL) |=> !r.cmp_latch;
   endproperty
   a_zero_ctrl: assert property (p_zero_ctrl) else $error("latch not cleared");
   property p_flag;
      @(posedge clk_in) disable iff (!arst_n_in)
      (ce_in && is_cmp && cmp_match) |=> match_event_flag_out;
   endproperty
   a_flag: assert property (p_flag) else $error("match flag not set");
   property p_trig;
      @(posedge clk_in) disable iff (!arst_n_in)
      conv_trig_out |-> $past(match_event_flag_out) && $past(trig_source_sel_in);
   endproperty
   a_trig: assert property (p_trig) else $error("trigger without cause");
   property p_trig_once;
      @(posedge clk_in) disable iff (!arst_n_in)
      (ce_in && conv_trig_out) |=> !conv_trig_out;
   endproperty
   a_trig_once: assert property (p_trig_once) else $error("trigger longer than one cycle");
   property p_reset;
      @(posedge clk_in) disable iff (!arst_n_in)
      counter_reset_out |-> $past(conv_trig_out);
   endproperty
   a_reset: assert property (p_reset) else $error("reset without trigger");
   property p_wake;
      @(posedge clk_in) disable iff (!arst_n_in)
      wake_out |-> $past(match_irq_enable_in) && $past(sleep_in);
   endproperty
   a_wake: assert property (p_wake) else $error("spurious wake");
   property p_driver;
      @(posedge clk_in) disable iff (!arst_n_in)
      pin_out |-> pin_oe_out;
   endproperty
   a_driver: assert property (p_driver) else $error("pin driven while off");
   property p_dis;
      @(posedge clk_in) disable iff (!arst_n_in)
      (ce_in && pin_driver_disable_in) |=> !pin_oe_out;
   endproperty
   a_dis: assert property (p_dis) else $error("driver not off");
   property p_oe_on;
      @(posedge clk_in) disable iff (!arst_n_in)
      (ce_in && !pin_driver_disable_in && pin_route_select_in) |=> pin_oe_out;
   endproperty
   a_oe_on: assert property (p_oe_on) else $error("driver not on");
   property p_period;
      @(posedge clk_in) disable iff (!arst_n_in)
      (pwm_time_counter_out == 8'h00 && $past(pwm_time_counter_out) != 8'h00)
         |-> $past(pwm_time_counter_out) >= $past(timebase_period_reg_in);
   endproperty
   a_period: assert property (p_period) else $error("early wrap");
endmodule : cpu_unit

// *** cpu_load_model.sv ***
// Far-side model: pin load with pull-down and converter trigger input
`timescale 1ns/100ps
module cpu_load_model
   import cpu_pkg::*;
(
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic drive_in,
   input wire logic oe_in,
   input wire logic trig_in,
   output logic level_out,
   output logic [7:0] trig_count_out
);
   // Weak pull-down on the load, so a released pin reads low, never the last value
   assign level_out = oe_in ? drive_in : 1'b0;
   // Converter counts every trigger pulse it sees
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         trig_count_out <= 8'h00;
      end else if (trig_in) begin
         trig_count_out <= trig_count_out + 8'h01;
      end
   end
endmodule : cpu_load_model

// *** cpu_unit_test.sv ***
// Self-checking bench for the compare and PWM unit
`timescale 1ns/100ps
module cpu_unit_test;
   import cpu_pkg::*;
   logic clk_in, arst_n_in, ce_in, tick, sleep, fclr, trig_sel, irq_en, dis, route, ext;
   logic [7:0] ctrl, cvh, cvl, per, tbc, tbcnt, tcount;
   logic [15:0] cnt;
   logic pin, oe, intl, flag, conv, crst, pev, wake, level;
   logic [3:0] modes [4] = '{MODE_CMP_SET, MODE_CMP_CLR, MODE_CMP_TOG, MODE_CMP_TOG};
   logic exp_lvl [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
   int err_total, check_count, hi, ev, mx;

   cpu_unit i_dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .ce_in(ce_in), .instr_tick_in(tick),
      .unit_control_reg_in(ctrl), .compare_value_high_in(cvh), .compare_value_low_in(cvl),
      .compare_time_counter_in(cnt), .timebase_period_reg_in(per), .timebase_control_reg_in(tbc),
      .ext_start_in(ext), .pin_driver_disable_in(dis), .pin_route_select_in(route),
      .trig_source_sel_in(trig_sel), .match_irq_enable_in(irq_en), .sleep_in(sleep),
      .flag_clear_in(fclr), .pin_out(pin), .pin_oe_out(oe), .internal_out(intl),
      .match_event_flag_out(flag), .conv_trig_out(conv), .counter_reset_out(crst),
      .period_event_out(pev), .wake_out(wake), .pwm_time_counter_out(tbcnt));
   cpu_load_model i_load (.clk_in(clk_in), .arst_n_in(arst_n_in), .drive_in(pin), .oe_in(oe),
      .trig_in(conv), .level_out(level), .trig_count_out(tcount));

   // Free-running system clock, 100 ns period
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   // All drives and samples land 10 ns after the rising edge
   task automatic step(input int n);
      repeat (n) @(posedge clk_in);
      #10;
   endtask : step
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check
   task automatic finish_test;
      $display("Checks %0d, errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : finish_test
   // One-cycle match: counter equals compare value for a single edge only
   task automatic match_once;
      cnt = 16'h1234;
      step(1);
      cnt = 16'h0000;
   endtask : match_once

   // Watchdog sized well above the roughly 550 cycles the tests need
   initial begin
      #500000;
      err_total++;
      $display("Error %0t: watchdog expired", $time);
      finish_test();
   end

   initial begin
      arst_n_in = 1'b0; ce_in = 1'b1; ext = 1'b0; sleep = 1'b0; fclr = 1'b0; trig_sel = 1'b0;
      irq_en = 1'b0; ctrl = 8'h00; cvh = 8'h12; cvl = 8'h34; cnt = 16'h0000; per = 8'h00; tbc = 8'h00;
      tick = 1'b1;
      dis = 1'b0;
      route = 1'b1;
      step(8);
      arst_n_in = 1'b1;
      step(1);
      // Driver is enabled and routed, so only the output enable rises on the first edge
      check({pin, oe, intl, flag, conv, crst, pev, wake}, 16'h0040, "outputs after reset");
      // Set, clear and toggle on a single-edge match each
      for (int i = 0; i < 4; i++) begin
         ctrl = {4'h0, modes[i]};
         step(1);
         match_once();
         check(flag, 16'h0001, "match flag");
         check(intl, exp_lvl[i], "internal output");
         check(level, exp_lvl[i], "pin level at load");
         fclr = 1'b1;
         step(1);
         fclr = 1'b0;
         check(flag, 16'h0000, "flag after clear");
      end
      // Driver off releases the pin even with the latch high
      ctrl = {4'h0, MODE_CMP_SET};
      match_once();
      dis = 1'b1;
      step(1);
      check({oe, level}, 16'h0000, "driver disabled");
      dis = 1'b0;
      ctrl = 8'h00;
      step(1);
      check(intl, 16'h0000, "latch after control cleared");
      // Trigger mode: flag, then conversion trigger, then counter reset, cancelled on the second pass by a compare rewrite
      fclr = 1'b1;
      step(1);
      fclr = 1'b0;
      ctrl = {4'h0, MODE_CMP_TRIG};
      trig_sel = 1'b1;
      for (int k = 0; k < 2; k++) begin
         cnt = 16'h1234;
         step(1);
         check(flag, 16'h0001, "trigger mode flag");
         step(1);
         check(conv, 16'h0001, "conversion trigger");
         if (k == 1) cvl = 8'h35;
         step(1);
         check(crst, k == 0 ? 16'h0001 : 16'h0000, "counter reset");
         cnt = 16'h0000;
         cvl = 8'h34;
         fclr = 1'b1;
         step(1);
         fclr = 1'b0;
      end
      check(tcount, 16'h0002, "triggers seen by converter");
      // Match during sleep with interrupt enabled wakes the device
      trig_sel = 1'b0;
      ctrl = {4'h0, MODE_CMP_SET};
      sleep = 1'b1;
      irq_en = 1'b1;
      step(1);
      match_once();
      check(wake, 16'h0001, "wake pulse");
      sleep = 1'b0;
      // PWM: period 8, prescale 1:4, duty 10 of 32 steps, postscale 1:1 to 1:3
      ctrl = {2'b00, 2'b10, MODE_PWM};
      cvl = 8'h02;
      per = 8'h07;
      for (int p = 0; p < 3; p++) begin
         tbc = {4'hA, p[3:0]};
         step(64);
         hi = 0;
         ev = 0;
         mx = 0;
         repeat (32 * (p + 1)) begin
            step(1);
            hi += int'(level);
            ev += int'(pev);
            if (int'(tbcnt) > mx) mx = int'(tbcnt);
         end
         check(hi[15:0], 16'(10 * (p + 1)), "pwm high cycles");
         check(ev[15:0], 16'h0001, "postscaled period events");
         check(mx[15:0], 16'h0007, "timebase top count");
      end
      // One-shot: after its period the timebase waits for the start input
      tbc = 8'hA8;
      step(40);
      mx = 0;
      repeat (32) begin
         step(1);
         if (int'(tbcnt) > mx) mx = int'(tbcnt);
      end
      check(mx[15:0], 16'h0000, "one-shot waits for start");
      ext = 1'b1;
      step(12);
      check(tbcnt, 16'h0002, "one-shot running");
      // Clock enable low holds every state bit
      ce_in = 1'b0;
      step(10);
      check(tbcnt, 16'h0002, "frozen by clock enable");
      ce_in = 1'b1;
      step(40);
      check(tbcnt, 16'h0000, "one-shot stopped after one period");
      finish_test();
   end
endmodule : cpu_unit_test
